// [sltx_defines.svh]
// Shared constants for the serial link transmit application sinks.
`ifndef SLTX_DEFINES_SVH
`define SLTX_DEFINES_SVH
`define SLTX_WORD_W        32
`define SLTX_CMD_W_CRC     6
`define SLTX_CMD_W_ALONE   18
`define SLTX_REG_ADDR_W    10
`define SLTX_ALERT_LEAD    8'h04
`define SLTX_TRAIN_CYCLES  8'h10
`define SLTX_ZERO_WORD     32'h0000_0000
`endif

// [sltx_pkg.sv]
// Types used by the device end of the transmit application sinks.
package sltx_pkg;
   typedef enum logic [1:0] {
      SLTX_IDLE,
      SLTX_TRAIN,
      SLTX_ALERT,
      SLTX_USER
   } sltx_phase_t;
endpackage

// [sltx_if.sv]
// Interface joining the application source to the transmit sinks.
`timescale 1ns/1ps
`default_nettype none
`include "sltx_defines.svh"
interface sltx_if #(
   parameter int LANES     = 1,
   parameter int SMP_W     = 128,
   parameter int CTL_W     = 16,
   parameter int CMD_W     = 18
);
   logic                      reg_write_strobe;
   logic [`SLTX_REG_ADDR_W-1:0] reg_addr;
   logic                      reg_read_strobe;
   logic [`SLTX_WORD_W-1:0]   reg_write_word;
   logic [`SLTX_WORD_W-1:0]   reg_read_word;
   logic                      reg_stall;
   logic [SMP_W-1:0]          sample_in_bus;
   logic [CTL_W-1:0]          sample_ctrl_bits_in;
   logic                      sample_in_valid;
   logic                      sample_in_ready;
   logic                      link_accept_soon;
   logic [LANES*CMD_W-1:0]    lane_command_bus;
   logic                      lane_command_valid;
   logic                      lane_command_ready;

   // The device end.
   modport dev (
      input  reg_write_strobe, reg_addr, reg_read_strobe, reg_write_word,
      output reg_read_word, reg_stall,
      input  sample_in_bus, sample_ctrl_bits_in, sample_in_valid,
      output sample_in_ready, link_accept_soon,
      input  lane_command_bus, lane_command_valid,
      output lane_command_ready
   );
   // The application end.
   modport app (
      output reg_write_strobe, reg_addr, reg_read_strobe, reg_write_word,
      input  reg_read_word, reg_stall,
      output sample_in_bus, sample_ctrl_bits_in, sample_in_valid,
      input  sample_in_ready, link_accept_soon,
      output lane_command_bus, lane_command_valid,
      input  lane_command_ready
   );
endinterface
`default_nettype wire

// [sltx_app_src.sv]
// Application end: drives register writes, samples and lane commands.
`timescale 1ns/1ps
`default_nettype none
`include "sltx_defines.svh"
module sltx_app_src #(
   parameter int LANES = 1,
   parameter int SMP_W = 128,
   parameter int CTL_W = 16,
   parameter int CMD_W = 18
) (
   // Clock and reset.
   input  wire logic                      ref_clk_in,
   input  wire logic                      rst_b_in,
   // Register request from user logic.
   input  wire logic                      usr_wr_in,
   input  wire logic                      usr_rd_in,
   input  wire logic [`SLTX_REG_ADDR_W-1:0] usr_addr_in,
   input  wire logic [`SLTX_WORD_W-1:0]   usr_wdata_in,
   output logic      [`SLTX_WORD_W-1:0]   usr_rdata_out,
   // Sample and command supply from user logic.
   input  wire logic [SMP_W-1:0]          usr_samples_in,
   input  wire logic [CTL_W-1:0]          usr_ctrl_in,
   input  wire logic [LANES*CMD_W-1:0]    usr_cmd_in,
   output logic                           usr_take_out,
   output logic                           usr_soon_out,
   // Link to the device.
   sltx_if.app                            lnk
);
   logic [`SLTX_WORD_W-1:0] rdata;
   logic [`SLTX_WORD_W-1:0] next_rdata;

   // Register port: a write always carries its word with the strobe.
   always_comb begin
      lnk.reg_write_strobe = usr_wr_in;    // RULE1
      lnk.reg_write_word   = usr_wdata_in; // RULE1
      lnk.reg_read_strobe  = usr_rd_in;
      lnk.reg_addr         = usr_addr_in;
   end

   // Read answers arrive in the access cycle, so capture there.
   always_comb begin
      next_rdata = rdata;
      if (usr_rd_in && !lnk.reg_stall) begin
         next_rdata = lnk.reg_read_word; // RULE2
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata <= `SLTX_ZERO_WORD;
      end else begin
         rdata <= next_rdata;
      end
   end
   assign usr_rdata_out = rdata;

   // Samples and commands are always valid while the sinks are ready.
   always_comb begin
      lnk.sample_in_bus       = usr_samples_in;   // RULE4 RULE5 RULE6
      lnk.sample_ctrl_bits_in = usr_ctrl_in;
      lnk.sample_in_valid     = lnk.sample_in_ready;    // RULE8
      lnk.lane_command_bus    = usr_cmd_in;       // RULE11 RULE12 RULE13
      lnk.lane_command_valid  = lnk.lane_command_ready; // RULE14
   end

   assign usr_take_out = lnk.sample_in_ready;
   assign usr_soon_out = lnk.link_accept_soon;
endmodule
`default_nettype wire

// [sltx_dev_sink.sv]
// Device end: register port, sample sink and lane command sink.
// Notes on behaviour
// RULE1: Master writes with strobe and 32-bit word.
// RULE2: Every read returns a 32-bit word.
// RULE3: Stall output is always held low.
// RULE4: Sample width is M*S*multiplier*N bits; the code makes it LANES*M*S*width_multiplier*N.
// RULE5: Samples packed big endian, first octet top.
// RULE6: Lane 0 sits in the top slice.
// RULE7: Control bits are inserted beside sample data.
// RULE8: Source keeps samples valid while ready.
// RULE9: Sample ready only in user-data phase.
// RULE10: Frame-ready rises fixed time before ready.
// RULE11: One command per lane per cycle.
// RULE12: Lane 0 command in top slice.
// RULE13: Command width 6 with CRC, else 18.
// RULE14: Source keeps commands valid while ready.
// RULE15: Command ready in user-data phase, latency zero.
// RULE16: Readies low outside user data; ignore inputs.
`timescale 1ns/1ps
`default_nettype none
`include "sltx_defines.svh"
module sltx_dev_sink #(
   parameter int M              = 1,
   parameter int S              = 8,
   parameter int width_multiplier = 1,
   parameter int N              = 16,
   parameter int CS             = 2,
   parameter int LANES          = 1,
   parameter bit CRC12_MODE     = 1'b0,
   parameter logic [7:0] TRAIN_CYCLES = `SLTX_TRAIN_CYCLES,
   parameter logic [7:0] ALERT_LEAD   = `SLTX_ALERT_LEAD,
   parameter int SMP_W          = LANES*M*S*width_multiplier*N, // RULE4
   parameter int CTL_W          = LANES*M*S*width_multiplier*CS,
   parameter int CMD_W          = CRC12_MODE ? `SLTX_CMD_W_CRC : `SLTX_CMD_W_ALONE // RULE13
) (
   // Clock and reset.
   input  wire logic                      ref_clk_in,
   input  wire logic                      rst_b_in,
   // Link enable from link bring-up logic.
   input  wire logic                      link_enable_in,
   // Link to the application end.
   sltx_if.dev                            lnk,
   // Taken samples with control bits, per lane.
   output logic      [SMP_W-1:0]          tx_sample_out,
   output logic      [CTL_W-1:0]          tx_ctrl_out,
   output logic                           tx_sample_valid_out,
   // Taken commands per lane.
   output logic      [CMD_W-1:0]          tx_cmd_out [LANES],
   output logic                           tx_cmd_valid_out,
   // Last written register word.
   output logic      [`SLTX_WORD_W-1:0]   cfg_word_out
);
   sltx_pkg::sltx_phase_t phase;
   sltx_pkg::sltx_phase_t next_phase;
   logic [7:0]              cnt;
   logic [7:0]              next_cnt;
   logic [`SLTX_WORD_W-1:0] cfg;
   logic [`SLTX_WORD_W-1:0] next_cfg;
   logic [SMP_W-1:0]        smp;
   logic [SMP_W-1:0]        next_smp;
   logic [CTL_W-1:0]        ctl;
   logic [CTL_W-1:0]        next_ctl;
   logic                    smp_v;
   logic                    next_smp_v;
   logic [LANES*CMD_W-1:0]  cmd;
   logic [LANES*CMD_W-1:0]  next_cmd;
   logic                    cmd_v;
   logic                    next_cmd_v;
   logic                    user_phase;

   // Phase walk: train, then alert the source, then user data.
   // The alert stage gives the source a fixed lead before ready.
   always_comb begin
      next_phase = phase;
      next_cnt   = cnt;
      if (!link_enable_in) begin
         next_phase = sltx_pkg::SLTX_IDLE;
         next_cnt   = 8'h00;
      end else begin
         unique case (phase)
            sltx_pkg::SLTX_IDLE: begin
               next_phase = sltx_pkg::SLTX_TRAIN;
               next_cnt   = 8'h00;
            end
            sltx_pkg::SLTX_TRAIN: begin
               next_cnt = cnt + 8'h01;
               if (cnt == TRAIN_CYCLES - 8'h01) begin
                  next_phase = sltx_pkg::SLTX_ALERT;
                  next_cnt   = 8'h00;
               end
            end
            sltx_pkg::SLTX_ALERT: begin
               next_cnt = cnt + 8'h01;
               if (cnt == ALERT_LEAD - 8'h01) begin // RULE10
                  next_phase = sltx_pkg::SLTX_USER;
                  next_cnt   = 8'h00;
               end
            end
            sltx_pkg::SLTX_USER: begin
               next_cnt = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         phase <= sltx_pkg::SLTX_IDLE;
         cnt   <= 8'h00;
      end else begin
         phase <= next_phase;
         cnt   <= next_cnt;
      end
   end

   // Readies only in user data, with zero ready latency.
   assign user_phase              = (phase == sltx_pkg::SLTX_USER);
   assign lnk.sample_in_ready     = user_phase;                  // RULE9 RULE16
   assign lnk.lane_command_ready  = user_phase;                  // RULE15 RULE16
   assign lnk.link_accept_soon    = (phase == sltx_pkg::SLTX_ALERT) || user_phase; // RULE10

   // Register port never stalls; reads answer in the access cycle.
   assign lnk.reg_stall     = 1'b0;                              // RULE3
   assign lnk.reg_read_word = lnk.reg_read_strobe ? cfg : `SLTX_ZERO_WORD; // RULE2

   always_comb begin
      next_cfg = cfg;
      if (lnk.reg_write_strobe) begin
         next_cfg = lnk.reg_write_word;
      end
   end

   // Sink capture. Inputs while not ready are ignored entirely.
   // Bus order is kept as is, so lane 0 stays in the top slice.
   always_comb begin
      next_smp   = smp;
      next_ctl   = ctl;
      next_cmd   = cmd;
      next_smp_v = 1'b0;
      next_cmd_v = 1'b0;
      if (user_phase) begin                                      // RULE16
         next_smp   = lnk.sample_in_bus;                         // RULE5 RULE6
         next_ctl   = lnk.sample_ctrl_bits_in;                   // RULE7
         next_smp_v = lnk.sample_in_valid;
         next_cmd   = lnk.lane_command_bus;                      // RULE11
         next_cmd_v = lnk.lane_command_valid;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cfg   <= `SLTX_ZERO_WORD;
         smp   <= '0;
         ctl   <= '0;
         smp_v <= 1'b0;
         cmd   <= '0;
         cmd_v <= 1'b0;
      end else begin
         cfg   <= next_cfg;
         smp   <= next_smp;
         ctl   <= next_ctl;
         smp_v <= next_smp_v;
         cmd   <= next_cmd;
         cmd_v <= next_cmd_v;
      end
   end

   // Split commands per lane, lane 0 from the top slice.
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      assign tx_cmd_out[g] = cmd[(LANES-g)*CMD_W-1 -: CMD_W];   // RULE12 RULE13
   end

   assign tx_sample_out       = smp;
   assign tx_ctrl_out         = ctl;
   assign tx_sample_valid_out = smp_v;
   assign tx_cmd_valid_out    = cmd_v;
   assign cfg_word_out        = cfg;
endmodule
`default_nettype wire

// [sltx_link_properties.sv]
// Concurrent checks on the link that joins the two ends.
`timescale 1ns/1ps
`default_nettype none
module sltx_link_properties (
   // Clock and reset.
   input wire logic        ref_clk_in,
   input wire logic        rst_b_in,
   // Register port.
   input wire logic        reg_write_strobe,
   input wire logic        reg_read_strobe,
   input wire logic [31:0] reg_write_word,
   input wire logic [31:0] reg_read_word,
   input wire logic        reg_stall,
   // Sample and command handshakes.
   input wire logic        sample_in_ready,
   input wire logic        link_accept_soon,
   input wire logic        lane_command_valid,
   input wire logic        lane_command_ready
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);

   // Register port: no stall, and a read shows the word written just before.
   stall_low_a: assert property (!reg_stall) else $error("stall raised");
   rd_idle_a: assert property (!reg_read_strobe |-> reg_read_word == 32'h0)
      else $error("read word without read");
   wr_then_rd_a: assert property (reg_write_strobe ##1 (reg_read_strobe && !reg_write_strobe)
      |-> reg_read_word == $past(reg_write_word)) else $error("read misses last write");
   rd_hold_a: assert property ((reg_read_strobe && !reg_write_strobe) [*2]
      |-> $stable(reg_read_word)) else $error("read word moved");

   // Readiness: both sinks open together, only after a lead of two cycles.
   ready_pair_a: assert property (lane_command_ready == sample_in_ready)
      else $error("sink readies differ");
   ready_soon_a: assert property (sample_in_ready |-> link_accept_soon)
      else $error("ready without notice");
   soon_lead_a: assert property ($rose(sample_in_ready)
      |-> $past(link_accept_soon, 2) && !$past(link_accept_soon, 3)) else $error("lead wrong");
   alert_len_a: assert property ($rose(link_accept_soon)
      |-> (!sample_in_ready) [*2] ##1 sample_in_ready) else $error("ready not on time");

   // Main scenarios.
   wr_rd_c: cover property (reg_write_strobe ##1 reg_read_strobe);
   open_c: cover property ($rose(sample_in_ready));
   cmd_c: cover property (lane_command_ready && lane_command_valid);
endmodule
`default_nettype wire

// [sltx_app_sinks_test.sv]
// Self-checking bench for both ends of the transmit application sinks.
`timescale 1ns/1ps
`default_nettype none
module sltx_app_sinks_test;
   logic         ref_clk_in, rst_b_in, link_enable_in, usr_wr_in, usr_rd_in;
   logic         usr_take_out, usr_soon_out, tx_sample_valid_out, tx_cmd_valid_out;
   logic [9:0]   usr_addr_in;
   logic [31:0]  usr_wdata_in, usr_rdata_out, cfg_word_out, usr_ctrl_in, tx_ctrl_out;
   logic [255:0] usr_samples_in, tx_sample_out;
   logic [35:0]  usr_cmd_in;
   logic [17:0]  tx_cmd_out [2];
   int           miscompares, compares, n, lead;

   // Two lanes exercise the lane order; short training and notice keep the run brief.
   localparam int         TB_LANES = 2;
   localparam int         TB_SMP_W = 256;
   localparam int         TB_CTL_W = 32;
   localparam int         TB_CMD_W = 18;
   localparam logic [7:0] TB_TRAIN = 8'h04;
   localparam logic [7:0] TB_LEAD  = 8'h02;

   // Both ends face each other across one interface.
   sltx_if #(.LANES(TB_LANES), .SMP_W(TB_SMP_W), .CTL_W(TB_CTL_W), .CMD_W(TB_CMD_W)) lnk ();
   sltx_app_src #(
      .LANES(TB_LANES), .SMP_W(TB_SMP_W), .CTL_W(TB_CTL_W), .CMD_W(TB_CMD_W)
   ) u_sltx_app_src (
      .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .usr_wr_in(usr_wr_in),
      .usr_rd_in(usr_rd_in), .usr_addr_in(usr_addr_in), .usr_wdata_in(usr_wdata_in),
      .usr_rdata_out(usr_rdata_out), .usr_samples_in(usr_samples_in),
      .usr_ctrl_in(usr_ctrl_in), .usr_cmd_in(usr_cmd_in), .usr_take_out(usr_take_out),
      .usr_soon_out(usr_soon_out), .lnk(lnk));
   // Short training and a two-cycle notice keep the run brief.
   sltx_dev_sink #(
      .LANES(TB_LANES), .TRAIN_CYCLES(TB_TRAIN), .ALERT_LEAD(TB_LEAD)
   ) u_sltx_dev_sink (
      .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .link_enable_in(link_enable_in),
      .lnk(lnk), .tx_sample_out(tx_sample_out), .tx_ctrl_out(tx_ctrl_out),
      .tx_sample_valid_out(tx_sample_valid_out), .tx_cmd_out(tx_cmd_out),
      .tx_cmd_valid_out(tx_cmd_valid_out), .cfg_word_out(cfg_word_out));
   sltx_link_properties u_sltx_link_properties (
      .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
      .reg_write_strobe(lnk.reg_write_strobe), .reg_read_strobe(lnk.reg_read_strobe),
      .reg_write_word(lnk.reg_write_word), .reg_read_word(lnk.reg_read_word),
      .reg_stall(lnk.reg_stall), .sample_in_ready(lnk.sample_in_ready),
      .link_accept_soon(lnk.link_accept_soon), .lane_command_valid(lnk.lane_command_valid),
      .lane_command_ready(lnk.lane_command_ready));

   // A 40 ns clock.
   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end

   // Counts every comparison and reports a mismatch at once.
   task automatic check(input string what, input logic [255:0] exp, input logic [255:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic final_report;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // One write cycle, then two read cycles whose answer comes at once.
   task automatic reg_access(input logic [31:0] d);
      @(posedge ref_clk_in);
      usr_wr_in <= 1'b1;
      usr_wdata_in <= d;
      @(posedge ref_clk_in);
      usr_wr_in <= 1'b0;
      usr_rd_in <= 1'b1;
      @(negedge ref_clk_in);
      check("read word", {224'h0, d}, {224'h0, lnk.reg_read_word});
      @(posedge ref_clk_in);
      #1 check("captured word", {224'h0, d}, {224'h0, usr_rdata_out});
      // The read is held one more cycle so its word is seen to stay put.
      @(negedge ref_clk_in);
      check("held word", {224'h0, d}, {224'h0, lnk.reg_read_word});
      @(posedge ref_clk_in);
      usr_rd_in <= 1'b0;
   endtask

   // Waits for the sinks to open and counts cycles of advance notice.
   task automatic wait_take;
      lead = 0;
      for (n = 0; n < 200 && usr_take_out !== 1'b1; n++) begin
         @(posedge ref_clk_in);
         #1 if (usr_soon_out === 1'b1) lead++;
      end
      if (n == 200) begin
         miscompares++;
         final_report();
      end
   endtask

   // Beats carry a marker octet at the top and the beat number at the bottom of each lane slice.
   function automatic logic [255:0] smp(input int i);
      return {8'ha1, 112'h0, 8'(i), 8'hb2, 112'h0, 8'(i)};
   endfunction

   initial begin
      {rst_b_in, link_enable_in, usr_wr_in, usr_rd_in} = 4'h0;
      {usr_addr_in, usr_wdata_in, usr_ctrl_in, usr_cmd_in} = '0;
      usr_samples_in = smp(9);
      repeat (16) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      reg_access(32'ha5c3_0f12);
      reg_access(32'h0000_0001);
      check("cfg word", 256'h1, {224'h0, cfg_word_out});
      // Offered data is dropped while the sinks are closed.
      check("early sample", 256'h0, {255'h0, tx_sample_valid_out});
      check("early data", 256'h0, tx_sample_out);
      check("early cmd", 256'h0, {255'h0, tx_cmd_valid_out});
      @(posedge ref_clk_in);
      link_enable_in <= 1'b1;
      wait_take();
      // The count also takes in the first open cycle, where notice is still high.
      check("notice lead", 256'(TB_LEAD + 1), 256'(lead));
      // Back-to-back beats; each shows on the outputs one cycle after it is taken.
      for (int i = 0; i < 5; i++) begin
         @(posedge ref_clk_in);
         usr_samples_in <= smp(i);
         usr_ctrl_in <= 32'hc000_0000 + i;
         usr_cmd_in <= {18'h3_0000 + 18'(i), 18'h0_0100 + 18'(i)};
         #1 if (i > 0) begin
            check("sample", smp(i - 1), tx_sample_out);
            check("ctrl", 256'(32'hc000_0000 + i - 1), {224'h0, tx_ctrl_out});
            check("cmd lane0", 256'(18'h3_0000 + i - 1), {238'h0, tx_cmd_out[0]});
            check("cmd lane1", 256'(18'h0_0100 + i - 1), {238'h0, tx_cmd_out[1]});
            check("valids", 256'h3, {254'h0, tx_sample_valid_out, tx_cmd_valid_out});
         end
      end
      // Dropping the enable closes both sinks at once.
      @(posedge ref_clk_in);
      link_enable_in <= 1'b0;
      @(posedge ref_clk_in);
      #1 check("closed", 256'h0, {254'h0, usr_take_out, lnk.lane_command_ready});
      @(posedge ref_clk_in);
      #1 check("closed valid", 256'h0, {255'h0, tx_sample_valid_out});
      final_report();
   end
endmodule
`default_nettype wire
